//--- slr_pkg.sv
// Constants and types for the scanline table run engine.
// Assumes a 16-bit word memory port and an APB register bus with 32-bit data.
package slr_pkg;

    // =========================================================
    // Register map (byte offsets)
    localparam logic [7:0] SLR_OFF_CTRL = 8'h00;
    localparam logic [7:0] SLR_OFF_TABLE = 8'h04;
    localparam logic [7:0] SLR_OFF_INIT = 8'h08;
    localparam logic [7:0] SLR_OFF_WARP = 8'h0c;
    localparam logic [7:0] SLR_OFF_BAND = 8'h10;
    localparam logic [7:0] SLR_OFF_STATUS = 8'h14;
    localparam logic [7:0] SLR_OFF_CUR = 8'h18;
    localparam logic [7:0] SLR_OFF_RESUME = 8'h1c;

    // Control and status bit positions
    localparam int SLR_CTRL_START = 0;
    localparam int SLR_CTRL_ORIENT = 1;
    localparam int SLR_CTRL_BANDED = 2;
    localparam int SLR_CTRL_RESUME = 3;
    localparam int SLR_STAT_BUSY = 0;
    localparam int SLR_STAT_DONE = 1;
    localparam int SLR_STAT_FAULT = 2;

    // Reset values
    localparam logic [31:0] SLR_RST_WORD = 32'h0000_0000;
    localparam logic [2:0] SLR_RST_CTRL = 3'h0;

    // =========================================================
    // Specifier identification
    localparam int SLR_ID16_BIT = 15;
    localparam logic [1:0] SLR_ID32 = 2'h2;
    localparam logic [1:0] SLR_ID48 = 2'h3;
    localparam logic [31:0] SLR_WORD_BYTES = 32'h0000_0002;
    localparam logic [15:0] SLR_NULL_SPEC = 16'h0000;

    typedef enum logic [1:0] {SLR_K16, SLR_K32, SLR_K48} slr_kind_e;

    typedef struct packed {
        slr_kind_e kind;
        logic [1:0] vertical_move;
        logic [31:0] horizontal_move;
        logic [31:0] combined_move;
        logic [13:0] run_pixel_count;
    } slr_spec_s;

    typedef struct packed {
        logic [31:0] addr;
        logic [13:0] len;
    } slr_run_s;

endpackage

//--- slr_engine.sv
// Scanline table run engine: APB registers, table fetch, run issue.
// Assumes a word memory answering mem_req with a one-cycle mem_ack and
// a drawing unit that takes run requests by valid/ready.
`timescale 1ns/1ns
module slr_engine
    import slr_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic mem_req,
    output logic [31:0] mem_addr,
    input wire logic mem_ack,
    input wire logic [15:0] mem_rdata,
    output logic run_valid,
    output slr_run_s run,
    input wire logic run_ready,
    output logic band_fault
);

    typedef enum logic [1:0] {S_IDLE, S_FETCH, S_EXEC, S_DRAW} slr_state_e;

    slr_state_e state;
    logic [2:0] ctrl;
    logic [31:0] table_ptr;
    logic [31:0] init_addr;
    logic [31:0] warp;
    logic [31:0] band_end;
    logic [31:0] cur;
    logic [31:0] spec_ptr;
    logic [31:0] resume_ptr;
    logic [31:0] resume_cur;
    logic [31:0] disp_q;
    logic done;
    logic first;
    logic is_null;
    logic [1:0] idx;
    logic [1:0] need;
    logic [15:0] wbuf [3];
    logic wr_en;
    logic rd_en;
    logic mapped;
    logic start;
    logic rev_fetch;
    logic rev_path;
    logic [1:0] need_now;
    logic [1:0] slot;
    slr_spec_s spec;
    logic [31:0] disp;
    logic [31:0] target;
    logic fault_now;

    // =========================================================
    // Specifier decoding

    // Words held per specifier, from an end word (ids sit at both ends)
    function automatic logic [1:0] slr_words(input logic [15:0] w);
        if (!w[SLR_ID16_BIT]) begin
            return 2'h1;
        end else if (w[15:14] == SLR_ID32) begin
            return 2'h2;
        end
        return 2'h3;
    endfunction

    // Words are in address order: w0 lowest
    function automatic slr_spec_s slr_decode(input logic [15:0] w0,
                                             input logic [15:0] w1,
                                             input logic [15:0] w2);
        slr_spec_s s;
        s = '0;
        if (!w0[SLR_ID16_BIT]) begin
            s.kind = SLR_K16;
            s.vertical_move = {1'b0, w0[14]};
            s.horizontal_move = {{24{w0[13]}}, w0[13:6]};
            s.run_pixel_count = {8'h00, w0[5:0]};
        end else if (w0[15:14] == SLR_ID32) begin
            s.kind = SLR_K32;
            s.vertical_move = w0[13:12];
            s.run_pixel_count = {2'h0, w0[11:0]};
            s.horizontal_move = {{18{w1[13]}}, w1[13:0]};
        end else begin
            s.kind = SLR_K48;
            s.run_pixel_count = w0[13:0];
            s.combined_move = {{2{w1[15]}}, w1, w2[13:0]};
        end
        return s;
    endfunction

    // =========================================================
    // APB slave
    always_comb begin
        unique case (paddr[7:0])
            SLR_OFF_CTRL, SLR_OFF_TABLE, SLR_OFF_INIT, SLR_OFF_WARP,
            SLR_OFF_BAND, SLR_OFF_STATUS, SLR_OFF_CUR,
            SLR_OFF_RESUME: mapped = (paddr[31:8] == 24'h00_0000);
            default: mapped = 1'b0;
        endcase
    end

    assign wr_en = psel && penable && pready && pwrite && mapped;
    assign rd_en = psel && penable && !pready && !pwrite;
    assign start = wr_en && paddr[7:0] == SLR_OFF_CTRL
        && pwdata[SLR_CTRL_START] && state == S_IDLE;

    // One wait state: pready rises in the second access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel && penable && !pready;
            pslverr <= psel && penable && !pready && !mapped;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= SLR_RST_WORD;
        end else if (rd_en && !mapped) begin
            prdata <= SLR_RST_WORD;
        end else if (rd_en) begin
            unique case (paddr[7:0])
                SLR_OFF_CTRL: prdata <= {28'h000_0000, ctrl, 1'b0};
                SLR_OFF_TABLE: prdata <= table_ptr;
                SLR_OFF_INIT: prdata <= init_addr;
                SLR_OFF_WARP: prdata <= warp;
                SLR_OFF_BAND: prdata <= band_end;
                SLR_OFF_STATUS: prdata <= {29'h0000_0000, band_fault, done,
                                           state != S_IDLE};
                SLR_OFF_CUR: prdata <= cur;
                SLR_OFF_RESUME: prdata <= resume_ptr;
                default: prdata <= SLR_RST_WORD;
            endcase
        end
    end

    // Mode bits are latched with every write; start is only a pulse
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl <= SLR_RST_CTRL;
            table_ptr <= SLR_RST_WORD;
            init_addr <= SLR_RST_WORD;
            warp <= SLR_RST_WORD;
            band_end <= SLR_RST_WORD;
        end else if (wr_en) begin
            unique case (paddr[7:0])
                SLR_OFF_CTRL: ctrl <= pwdata[SLR_CTRL_RESUME:SLR_CTRL_ORIENT];
                SLR_OFF_TABLE: table_ptr <= {pwdata[31:1], 1'b0};
                SLR_OFF_INIT: init_addr <= pwdata;
                SLR_OFF_WARP: warp <= pwdata;
                SLR_OFF_BAND: band_end <= pwdata;
                default: ;
            endcase
        end
    end

    // =========================================================
    // Decode and address arithmetic
    assign rev_fetch = ctrl[SLR_CTRL_ORIENT - 1];
    assign rev_path = ctrl[SLR_CTRL_ORIENT - 1] && ctrl[SLR_CTRL_BANDED - 1];
    assign need_now = (idx == 2'h0) ? slr_words(mem_rdata) : need;
    // Backward walk meets the last word first: fill the buffer from the top
    assign slot = rev_fetch ? 2'(need_now - 2'h1 - idx) : idx;
    assign spec = slr_decode(wbuf[0], wbuf[1], wbuf[2]);

    always_comb begin
        if (spec.kind == SLR_K48) begin
            disp = spec.combined_move;
        end else begin
            disp = 32'({30'h0000_0000, spec.vertical_move} * warp)
                + spec.horizontal_move;
        end
        if (rev_path) begin
            target = cur - {18'h0_0000, spec.run_pixel_count};
        end else begin
            target = cur + disp;
        end
        // Lower band edge is never tested, so a negative move slips past
        fault_now = ctrl[SLR_CTRL_BANDED - 1]
            && target >= band_end;
    end

    // =========================================================
    // Engine
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= S_IDLE;
            mem_req <= 1'b0;
            mem_addr <= SLR_RST_WORD;
            cur <= SLR_RST_WORD;
            spec_ptr <= SLR_RST_WORD;
            disp_q <= SLR_RST_WORD;
            idx <= 2'h0;
            need <= 2'h1;
            first <= 1'b0;
            is_null <= 1'b0;
            run_valid <= 1'b0;
            run <= '0;
            wbuf[0] <= SLR_NULL_SPEC;
            wbuf[1] <= SLR_NULL_SPEC;
            wbuf[2] <= SLR_NULL_SPEC;
        end else begin
            unique case (state)
                S_IDLE: begin
                    if (start) begin
                        if (pwdata[SLR_CTRL_RESUME]) begin
                            mem_addr <= resume_ptr;
                            cur <= resume_cur;
                        end else begin
                            mem_addr <= table_ptr;
                            cur <= init_addr;
                        end
                        first <= 1'b1;
                        idx <= 2'h0;
                        mem_req <= 1'b1;
                        state <= S_FETCH;
                    end
                end
                S_FETCH: begin
                    if (mem_ack) begin
                        wbuf[slot] <= mem_rdata;
                        if (idx == 2'h0) begin
                            need <= need_now;
                            spec_ptr <= mem_addr;
                            is_null <= mem_rdata == SLR_NULL_SPEC;
                        end
                        if (rev_fetch) begin
                            mem_addr <= mem_addr - SLR_WORD_BYTES;
                        end else begin
                            mem_addr <= mem_addr + SLR_WORD_BYTES;
                        end
                        if (idx + 2'h1 == need_now) begin
                            mem_req <= 1'b0;
                            idx <= 2'h0;
                            state <= S_EXEC;
                        end else begin
                            idx <= idx + 2'h1;
                        end
                    end
                end
                S_EXEC: begin
                    if (fault_now) begin
                        state <= S_IDLE;
                    end else begin
                        // Only the run start saw the band test
                        run.addr <= target;
                        run.len <= spec.run_pixel_count;
                        disp_q <= disp;
                        // A zero count issues no run at all
                        run_valid <= spec.run_pixel_count != 14'h0000;
                        state <= S_DRAW;
                    end
                end
                S_DRAW: begin
                    if (!run_valid || run_ready) begin
                        run_valid <= 1'b0;
                        if (rev_path) begin
                            cur <= run.addr - disp_q;
                        end else begin
                            cur <= run.addr + {18'h0_0000, run.len};
                        end
                        first <= 1'b0;
                        // Closing null ends the table after being executed
                        if (is_null && !first) begin
                            state <= S_IDLE;
                        end else begin
                            mem_req <= 1'b1;
                            state <= S_FETCH;
                        end
                    end
                end
            endcase
        end
    end

    // =========================================================
    // Status and resume point
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            done <= 1'b0;
            band_fault <= 1'b0;
            resume_ptr <= SLR_RST_WORD;
            resume_cur <= SLR_RST_WORD;
        end else begin
            // Hardware set wins over a same-cycle write-one-to-clear
            if (state == S_DRAW && (!run_valid || run_ready)
                    && is_null && !first) begin
                done <= 1'b1;
            end else if (wr_en && paddr[7:0] == SLR_OFF_STATUS
                    && pwdata[SLR_STAT_DONE]) begin
                done <= 1'b0;
            end
            if (state == S_EXEC && fault_now) begin
                band_fault <= 1'b1;
                resume_ptr <= spec_ptr;
                resume_cur <= cur;
            end else if (wr_en && paddr[7:0] == SLR_OFF_STATUS
                    && pwdata[SLR_STAT_FAULT]) begin
                band_fault <= 1'b0;
            end
        end
    end

    // =========================================================
    // Checks
    apb_ready_a: assert property (@(posedge pclk) disable iff (!presetn)
        psel && penable && !pready |=> pready)
        else $error("pready missing after access cycle");
    fault_stop_a: assert property (@(posedge pclk) disable iff (!presetn)
        state == S_EXEC && fault_now |=> band_fault && state == S_IDLE
            && !run_valid)
        else $error("band fault did not end the transfer");
    run_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
        run_valid && !run_ready |=> run_valid && $stable(run))
        else $error("run request changed before taken");
    mem_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
        mem_req && !mem_ack |=> mem_req && $stable(mem_addr))
        else $error("memory request dropped early");
    fetch_dir_a: assert property (@(posedge pclk) disable iff (!presetn)
        state == S_FETCH && mem_ack |=> mem_addr == (rev_fetch
            ? $past(mem_addr) - SLR_WORD_BYTES
            : $past(mem_addr) + SLR_WORD_BYTES))
        else $error("fetch pointer moved the wrong way");
    short_run_a: assert property (@(posedge pclk) disable iff (!presetn)
        state == S_EXEC && spec.kind == SLR_K16
        |-> spec.run_pixel_count[13:6] == 8'h00)
        else $error("short specifier run over 63");
    fwd_addr_a: assert property (@(posedge pclk) disable iff (!presetn)
        state == S_DRAW && run_valid && run_ready && !rev_path
        |=> cur == $past(run.addr) + {18'h0_0000, $past(run.len)})
        else $error("current address not past the run");
    rev_addr_a: assert property (@(posedge pclk) disable iff (!presetn)
        state == S_DRAW && run_valid && run_ready && rev_path
        |=> cur == $past(run.addr) - $past(disp_q))
        else $error("reverse address not displaced");
    start_load_a: assert property (@(posedge pclk) disable iff (!presetn)
        start && !pwdata[SLR_CTRL_RESUME]
        |=> cur == $past(init_addr) && mem_req ##1 state == S_FETCH)
        else $error("order start did not load the address");
    err_read_a: assert property (@(posedge pclk) disable iff (!presetn)
        pready && pslverr && !pwrite |-> prdata == SLR_RST_WORD)
        else $error("unmapped read returned data");

endmodule // slr_engine

//--- slr_mem_model.sv
// Word memory partner for the scanline engine; tables are preloaded in mem.
// Assumes the engine holds mem_req and mem_addr steady until mem_ack.
`timescale 1ns/1ns
module slr_mem_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic slow,
    input wire logic mem_req,
    input wire logic [31:0] mem_addr,
    output logic mem_ack,
    output logic [15:0] mem_rdata
);
    logic [15:0] mem [0:255];
    int seed = 32'hd933;
    int gap = 0;

    // ==========================================================
    // Answer: one-cycle ack, at least two idle cycles between words
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mem_ack <= 1'b0;
            mem_rdata <= 16'h0000;
            gap = 0;
        end else if (mem_ack) begin
            mem_ack <= 1'b0;
            mem_rdata <= ~mem_rdata;
            gap = slow ? 1 + ($unsigned($random(seed)) % 4) : 1;
        end else if (mem_req && gap == 0) begin
            mem_ack <= 1'b1;
            mem_rdata <= mem[mem_addr[8:1]];
        end else begin
            // Toggle idle data so a late sample never matches by luck
            mem_rdata <= ~mem_rdata;
            if (gap != 0) gap--;
        end
    end
endmodule // slr_mem_model

//--- slr_engine_tb_top.sv
// Self-checking bench for slr_engine: APB master, run sink, table model.
// Assumes slr_mem_model as memory; expected runs come from a table model.
`timescale 1ns/1ns
module slr_engine_tb_top;
    import slr_pkg::*;
    localparam int WARP = 100;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] paddr = 32'h0;
    logic [31:0] pwdata = 32'h0;
    logic run_ready = 1'b0;
    logic slow = 1'b0;
    logic [31:0] prdata, mem_addr, rdv;
    logic pready, pslverr, mem_req, mem_ack, run_valid, band_fault;
    logic [15:0] mem_rdata;
    slr_run_s run;
    int errors = 0;
    int n_tests = 0;
    int seed = 32'hd933;
    int cur, wp;
    int nsp = 0;
    int dsp [0:7];
    int ln [0:7];
    logic [33:0] re;
    logic [33:0] rd_q [$];
    logic [45:0] run_q [$];

    always #4 pclk = ~pclk;

    slr_engine slr_engine_i (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .mem_req(mem_req), .mem_addr(mem_addr), .mem_ack(mem_ack),
        .mem_rdata(mem_rdata), .run_valid(run_valid), .run(run),
        .run_ready(run_ready), .band_fault(band_fault));
    slr_mem_model slr_mem_model_i (.pclk(pclk), .presetn(presetn),
        .slow(slow), .mem_req(mem_req), .mem_addr(mem_addr),
        .mem_ack(mem_ack), .mem_rdata(mem_rdata));

    // ==========================================================
    // Checking and closing
    task automatic chk(input logic [45:0] e, input logic [45:0] g);
        n_tests++;
        if (g !== e) begin
            errors++;
            $display("ERROR t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask

    task automatic give_verdict();
        $display("errors=%0d n_tests=%0d", errors, n_tests);
        if (errors == 0 && n_tests > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // Expected reads carry {ignore, pslverr, prdata}
    always @(posedge pclk) begin
        if (psel && penable && pready && !pwrite) begin
            re = rd_q.pop_front();
            if (!re[33]) chk({13'h0, re[32:0]}, {13'h0, pslverr, prdata});
        end
        if (run_valid && run_ready) chk(run_q.pop_front(), run);
    end

    // Drawing side stalls at random
    always @(posedge pclk) run_ready <= ($random(seed) % 3) != 0;

    // ==========================================================
    // APB master
    task automatic apb(input logic w, input logic [31:0] a,
                       input logic [31:0] d, input logic [33:0] e);
        if (!w) rd_q.push_back(e);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rdv = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        apb(1'b1, a, d, '0);
    endtask

    task automatic rd(input logic [31:0] a, input logic [31:0] d);
        apb(1'b0, a, 32'h0, {2'b00, d});
    endtask

    task automatic wait_idle();
        apb(1'b0, SLR_OFF_STATUS, 32'h0, {2'b10, 32'h0});
        while (rdv[SLR_STAT_BUSY] !== 1'b0)
            apb(1'b0, SLR_OFF_STATUS, 32'h0, {2'b10, 32'h0});
    endtask

    // ==========================================================
    // Table builder and run model
    task automatic put(input logic [15:0] w);
        slr_mem_model_i.mem[wp] = w;
        wp++;
    endtask

    task automatic spec(input int k, input int v, input int h, input int l);
        int z;
        z = v * WARP + h;
        if (k == 16) put({1'b0, v[0], h[7:0], l[5:0]});
        if (k == 32) begin
            put({2'b10, v[1:0], l[11:0]});
            put({2'b10, h[13:0]});
        end
        if (k == 48) begin
            put({2'b11, l[13:0]});
            put(z[29:14]);
            put({2'b11, z[13:0]});
        end
        dsp[nsp] = z;
        ln[nsp] = l;
        nsp++;
    endtask

    task automatic fwd(input int a, input int b);
        for (int i = a; i <= b; i++) begin
            cur += dsp[i];
            if (ln[i] != 0) run_q.push_back({cur, ln[i][13:0]});
            cur += ln[i];
        end
    endtask

    task automatic bwd();
        for (int i = nsp - 1; i >= 0; i--) begin
            cur -= ln[i];
            if (ln[i] != 0) run_q.push_back({cur, ln[i][13:0]});
            cur -= dsp[i];
        end
    endtask

    // ==========================================================
    // Scenarios
    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        for (int a = 0; a < 32; a += 4) rd(a, 32'h0);
        apb(1'b0, 32'h20, 32'h0, {2'b01, 32'h0});
        wr(SLR_OFF_TABLE, 32'h21);
        rd(SLR_OFF_TABLE, 32'h20);
        // Alias of a mapped offset: must read zero and never write
        apb(1'b0, 32'h104, 32'h0, {2'b01, 32'h0});
        wr(32'h108, 32'h5);
        rd(SLR_OFF_INIT, 32'h0);
        wp = 16;
        spec(16, 0, 0, 0);
        // Shift above -100 keeps this run start past the leading null
        spec(16, 1, $random(seed) % 100, $unsigned($random(seed)) % 64);
        spec(32, 2, -8192, 0);
        spec(48, -2, -50, 16383);
        spec(16, 0, 0, 0);
        // Upright unbanded page, prompt memory
        wr(SLR_OFF_WARP, WARP);
        wr(SLR_OFF_INIT, 20000);
        wr(SLR_OFF_TABLE, 32'h20);
        cur = 20000;
        fwd(0, 4);
        wr(SLR_OFF_CTRL, 32'h1);
        wait_idle();
        rd(SLR_OFF_CUR, cur);
        rd(SLR_OFF_STATUS, 32'h2);
        wr(SLR_OFF_STATUS, 32'h2);
        rd(SLR_OFF_STATUS, 32'h0);
        // Upside-down banded page, slow memory, table walked backward
        slow <= 1'b1;
        wr(SLR_OFF_BAND, 32'h7fff_ffff);
        wr(SLR_OFF_INIT, 100000);
        wr(SLR_OFF_TABLE, 32'h2e);
        cur = 100000;
        bwd();
        wr(SLR_OFF_CTRL, 32'h7);
        wait_idle();
        rd(SLR_OFF_CUR, cur);
        // Band end sits exactly at the 16-bit run start, then resume;
        // the leading null starts lower, so the first fault must be there
        slow <= 1'b0;
        wr(SLR_OFF_STATUS, 32'h6);
        wr(SLR_OFF_INIT, 20000);
        wr(SLR_OFF_TABLE, 32'h20);
        cur = 20000;
        fwd(0, 0);
        wr(SLR_OFF_BAND, cur + dsp[1]);
        wr(SLR_OFF_CTRL, 32'h5);
        wait_idle();
        @(negedge pclk);
        chk(1'b1, band_fault);
        rd(SLR_OFF_CUR, cur);
        rd(SLR_OFF_STATUS, 32'h4);
        rd(SLR_OFF_RESUME, 32'h22);
        wr(SLR_OFF_STATUS, 32'h4);
        @(negedge pclk);
        chk(1'b0, band_fault);
        wr(SLR_OFF_BAND, 32'h7fff_ffff);
        fwd(1, 4);
        wr(SLR_OFF_CTRL, 32'hd);
        wait_idle();
        rd(SLR_OFF_CUR, cur);
        chk(46'h0, run_q.size());
        give_verdict();
    end

    initial begin
        #400000;
        errors++;
        give_verdict();
    end
endmodule // slr_engine_tb_top
